// ==== inc/sclk_defines.vh ====
`ifndef SCLK_DEFINES_VH
`define SCLK_DEFINES_VH
// register indices on the plain register port
`define SCLK_ADDR_W 4
`define SCLK_IDX_PROTECT 4'h0
`define SCLK_IDX_CTRL0 4'h1
`define SCLK_IDX_CTRL1 4'h2
`define SCLK_IDX_OSD 4'h3
`define SCLK_IDX_STATUS 4'h4
// field positions
`define SCLK_PROTECT_PERMIT 0
`define SCLK_CTRL0_MAIN_STOP 5
`define SCLK_CTRL0_DIV_EN 6
`define SCLK_CTRL0_SRC_SEL 7
`define SCLK_CTRL1_PIN_SW 3
`define SCLK_CTRL1_LOSC_STOP 4
`define SCLK_CTRL1_DIV_LO 6
`define SCLK_CTRL1_DIV_HI 7
`define SCLK_OSD_ONCHIP_SEL 2
// status register fields
`define SCLK_STAT_MAIN_STABLE 0
`define SCLK_STAT_SRC_MAIN 1
`define SCLK_STAT_LOSC_RUN 2
`define SCLK_STAT_PIN_XTAL 3
// reset values
`define SCLK_RST_PROTECT 8'h00
`define SCLK_RST_CTRL0 8'h68
`define SCLK_RST_CTRL1 8'h20
`define SCLK_RST_OSD 8'h04
`define SCLK_ZERO8 8'h00
// stabilisation wait and divider
`define SCLK_STAB_CNT_W 16
`define SCLK_STAB_TIME_US 16'h0064
`define SCLK_CLK_MHZ 16'h0064
`define SCLK_STAB_CYCLES (`SCLK_STAB_TIME_US * `SCLK_CLK_MHZ)
`define SCLK_DIV_W 4
`define SCLK_DIV_ONE 4'h0
`define SCLK_DIV_TWO 4'h1
`define SCLK_DIV_FOUR 4'h3
`define SCLK_DIV_SIXTEEN 4'hF
`define SCLK_DIV_EIGHT 4'h7
// divider field codes in control 1
`define SCLK_DIVF_NONE 2'h0
`define SCLK_DIVF_HALF 2'h1
`define SCLK_DIVF_QUARTER 2'h2
// implemented bits per register
`define SCLK_PROTECT_MASK 8'h01
`define SCLK_CTRL0_MASK 8'hFE
`define SCLK_CTRL1_MASK 8'hFF
`define SCLK_OSD_MASK 8'h07
// unused upper status bits
`define SCLK_STAT_PAD_HI 7
`define SCLK_STAT_PAD_LO 4
`define SCLK_STAT_PAD 4'h0
// settle counter steps
`define SCLK_STAB_ZERO 16'h0000
`define SCLK_STAB_STEP 16'h0001
`define SCLK_STAB_LAST (`SCLK_STAB_CYCLES - `SCLK_STAB_STEP)
`endif

// ==== rtl/sclk_control.v ====
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "sclk_defines.vh"
module sclk_control (
   // clock and reset
   input wire core_clk,
   input wire reset_n,
   // register port
   input wire [`SCLK_ADDR_W-1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [7:0] reg_rdata_q,
   // oscillator and pin control
   output wire main_osc_enable,
   output wire low_speed_osc_enable,
   output wire crystal_pins_to_osc,
   input wire onchip_osc_ready,
   // clock selection
   output reg sysclk_from_main_q,
   output wire sysclk_from_slow,
   output wire cpu_clk_tick,
   output wire [`SCLK_DIV_W-1:0] cpu_div_limit
);
   // states of the main oscillator settle tracker
   localparam [1:0] STAB_OFF = 2'h0;
   localparam [1:0] STAB_WAIT = 2'h1;
   localparam [1:0] STAB_DONE = 2'h2;

   reg [7:0] protect_q;
   reg [7:0] ctrl0_q;
   reg [7:0] ctrl1_q;
   reg [7:0] osd_q;
   reg [1:0] stab_state_q;
   reg [1:0] stab_state_d;
   reg [`SCLK_STAB_CNT_W-1:0] stab_cnt_q;
   reg [`SCLK_STAB_CNT_W-1:0] stab_cnt_d;
   reg [7:0] rdata_d;
   reg [`SCLK_DIV_W-1:0] div_d;
   wire permit;
   wire wr_protect;
   wire wr_guarded;
   wire wr_ctrl0;
   wire wr_ctrl1;
   wire wr_osd;
   wire osc_request;
   wire main_stable;
   wire [7:0] status_word;

   // write decode
   assign permit = protect_q[`SCLK_PROTECT_PERMIT];
   assign wr_protect = reg_write && (reg_addr == `SCLK_IDX_PROTECT);
   // guarded registers only take writes while permitted
   assign wr_guarded = reg_write && permit;
   assign wr_ctrl0 = wr_guarded && (reg_addr == `SCLK_IDX_CTRL0);
   assign wr_ctrl1 = wr_guarded && (reg_addr == `SCLK_IDX_CTRL1);
   assign wr_osd = wr_guarded && (reg_addr == `SCLK_IDX_OSD);

   // write permit: the one register software can always reach
   always @(posedge core_clk) begin
      if (!reset_n) begin
         protect_q <= `SCLK_RST_PROTECT;
      end else if (wr_protect) begin
         // clearing the permit bit relocks the guarded registers
         protect_q <= reg_wdata & `SCLK_PROTECT_MASK;
      end
   end

   // control 0: stop, divider enable and source select; bit 0 reads 0
   always @(posedge core_clk) begin
      if (!reset_n) begin
         ctrl0_q <= `SCLK_RST_CTRL0;
      end else if (wr_ctrl0) begin
         ctrl0_q <= reg_wdata & `SCLK_CTRL0_MASK;
      end
   end

   // control 1: divider field, low-speed stop and pin switch
   always @(posedge core_clk) begin
      if (!reset_n) begin
         ctrl1_q <= `SCLK_RST_CTRL1;
      end else if (wr_ctrl1) begin
         ctrl1_q <= reg_wdata & `SCLK_CTRL1_MASK;
      end
   end

   // detect register: only the low three bits exist
   always @(posedge core_clk) begin
      if (!reset_n) begin
         osd_q <= `SCLK_RST_OSD;
      end else if (wr_osd) begin
         osd_q <= reg_wdata & `SCLK_OSD_MASK;
      end
   end

   // oscillator and pin steering
   assign main_osc_enable = ~ctrl0_q[`SCLK_CTRL0_MAIN_STOP];
   assign low_speed_osc_enable = ~ctrl1_q[`SCLK_CTRL1_LOSC_STOP];
   assign crystal_pins_to_osc = ctrl1_q[`SCLK_CTRL1_PIN_SW];

   // settle tracker restarts whenever the oscillator stops or loses its pins
   assign osc_request = main_osc_enable && crystal_pins_to_osc;
   always @* begin
      stab_state_d = stab_state_q;
      stab_cnt_d = stab_cnt_q;
      case (stab_state_q)
         STAB_OFF: begin
            stab_cnt_d = `SCLK_STAB_ZERO;
            if (osc_request) begin
               stab_state_d = STAB_WAIT;
            end
         end
         STAB_WAIT: begin
            if (!osc_request) begin
               stab_state_d = STAB_OFF;
               stab_cnt_d = `SCLK_STAB_ZERO;
            end else if (stab_cnt_q >= `SCLK_STAB_LAST) begin
               stab_state_d = STAB_DONE;
            end else begin
               stab_cnt_d = stab_cnt_q + `SCLK_STAB_STEP;
            end
         end
         STAB_DONE: begin
            if (!osc_request) begin
               stab_state_d = STAB_OFF;
               stab_cnt_d = `SCLK_STAB_ZERO;
            end
         end
         default: begin
            stab_state_d = STAB_OFF;
            stab_cnt_d = `SCLK_STAB_ZERO;
         end
      endcase
   end

   // settle tracker registers
   always @(posedge core_clk) begin
      if (!reset_n) begin
         stab_state_q <= STAB_OFF;
         stab_cnt_q <= `SCLK_STAB_ZERO;
      end else begin
         stab_state_q <= stab_state_d;
         stab_cnt_q <= stab_cnt_d;
      end
   end
   // informative only: selection is not blocked before the oscillator settles
   assign main_stable = (stab_state_q == STAB_DONE);

   // source selection: slow clock when select bit set
   assign sysclk_from_slow = ctrl0_q[`SCLK_CTRL0_SRC_SEL];
   always @(posedge core_clk) begin
      if (!reset_n) begin
         sysclk_from_main_q <= 1'b0;
      end else begin
         sysclk_from_main_q <= ~ctrl0_q[`SCLK_CTRL0_SRC_SEL] & ~osd_q[`SCLK_OSD_ONCHIP_SEL];
      end
   end

   // divider: field in control 1 when enable bit clear, else divide by 8
   always @* begin
      if (ctrl0_q[`SCLK_CTRL0_DIV_EN]) begin
         div_d = `SCLK_DIV_EIGHT;
      end else begin
         case (ctrl1_q[`SCLK_CTRL1_DIV_HI:`SCLK_CTRL1_DIV_LO])
            `SCLK_DIVF_NONE: div_d = `SCLK_DIV_ONE;
            `SCLK_DIVF_HALF: div_d = `SCLK_DIV_TWO;
            `SCLK_DIVF_QUARTER: div_d = `SCLK_DIV_FOUR;
            default: div_d = `SCLK_DIV_SIXTEEN;
         endcase
      end
   end
   assign cpu_div_limit = div_d;
   // cpu clock tick generator
   sclk_divider u_div (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .limit(div_d),
      .tick_q(cpu_clk_tick)
   );

   // status word: read-only view of the clock tree
   assign status_word[`SCLK_STAT_MAIN_STABLE] = main_stable;
   assign status_word[`SCLK_STAT_SRC_MAIN] = sysclk_from_main_q;
   assign status_word[`SCLK_STAT_LOSC_RUN] = low_speed_osc_enable & onchip_osc_ready;
   assign status_word[`SCLK_STAT_PIN_XTAL] = crystal_pins_to_osc;
   assign status_word[`SCLK_STAT_PAD_HI:`SCLK_STAT_PAD_LO] = `SCLK_STAT_PAD;

   // read port
   always @* begin
      case (reg_addr)
         `SCLK_IDX_PROTECT: rdata_d = protect_q;
         `SCLK_IDX_CTRL0: rdata_d = ctrl0_q;
         `SCLK_IDX_CTRL1: rdata_d = ctrl1_q;
         `SCLK_IDX_OSD: rdata_d = osd_q;
         `SCLK_IDX_STATUS: rdata_d = status_word;
         default: rdata_d = `SCLK_ZERO8;
      endcase
   end

   // read data stand for the one cycle after the strobe, zero otherwise
   always @(posedge core_clk) begin
      if (!reset_n) begin
         reg_rdata_q <= `SCLK_ZERO8;
      end else if (reg_read) begin
         reg_rdata_q <= rdata_d;
      end else begin
         reg_rdata_q <= `SCLK_ZERO8;
      end
   end
endmodule // sclk_control
`default_nettype wire

// ==== rtl/sclk_divider.v ====
`timescale 1ns/10ps
`default_nettype none
`include "sclk_defines.vh"
// cpu clock enable generator: one pulse every (limit+1) cycles
module sclk_divider (
   // clock and reset
   input wire core_clk,
   input wire reset_n,
   // control
   input wire [`SCLK_DIV_W-1:0] limit,
   // output
   output reg tick_q
);
   reg [`SCLK_DIV_W-1:0] count_q;
   wire wrap;
   assign wrap = (count_q >= limit);
   always @(posedge core_clk) begin
      if (!reset_n) begin
         count_q <= `SCLK_DIV_ONE;
         tick_q <= 1'b0;
      end else begin
         count_q <= wrap ? `SCLK_DIV_ONE : count_q + `SCLK_DIV_TWO;
         tick_q <= wrap;
      end
   end
endmodule // sclk_divider
`default_nettype wire

// ==== tb/sclk_control_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module sclk_control_asserts (
   // clock and reset
   input wire core_clk,
   input wire reset_n,
   // register port and clock outputs
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_write,
   input wire main_osc_enable,
   input wire low_speed_osc_enable,
   input wire crystal_pins_to_osc,
   input wire sysclk_from_main_q,
   input wire sysclk_from_slow,
   input wire cpu_clk_tick,
   input wire [3:0] cpu_div_limit
);
   logic ok_q;
   logic den_q;
   wire w1 = reg_write && ok_q && reg_addr == 4'h1;
   wire w2 = reg_write && ok_q && reg_addr == 4'h2;
   wire w3 = reg_write && ok_q && reg_addr == 4'h3;
   // shadows of the write permit bit and the divider enable bit
   always @(posedge core_clk) begin
      if (!reset_n) begin
         ok_q <= 1'b0;
         den_q <= 1'b1;
      end else begin
         if (reg_write && reg_addr == 4'h0) ok_q <= reg_wdata[0];
         if (w1) den_q <= reg_wdata[6];
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   a_main_run: assert property (w1 |=> main_osc_enable != $past(reg_wdata[5])) else $error("main");
   a_src_sel: assert property (w1 |=> sysclk_from_slow == $past(reg_wdata[7])) else $error("src");
   a_div_en: assert property (w1 && reg_wdata[6] |=> cpu_div_limit == 4'h7) else $error("div");
   a_slow_run: assert property (w2 |=> low_speed_osc_enable != $past(reg_wdata[4])) else $error("slow");
   a_pin_sw: assert property (w2 |=> crystal_pins_to_osc == $past(reg_wdata[3])) else $error("pins");
   a_tick_full: assert property ((cpu_div_limit == 4'h0) [*4] |-> cpu_clk_tick) else $error("tick");
   a_slow_sel: assert property (sysclk_from_slow |=> !sysclk_from_main_q) else $error("sel");
   a_onchip_pick: assert property (w3 && reg_wdata[2] |-> ##2 !sysclk_from_main_q) else $error("onchip");
   a_main_pick: assert property (w3 && !reg_wdata[2] && !sysclk_from_slow |->
      ##2 sysclk_from_main_q) else $error("xtal");
   a_div_none: assert property (w2 && reg_wdata[7:6] == 2'h0 && !den_q |=>
      cpu_div_limit == 4'h0) else $error("none");
   a_lock_hold: assert property (reg_write && !ok_q && reg_addr != 4'h0 |=>
      $stable({main_osc_enable, crystal_pins_to_osc, sysclk_from_slow, cpu_div_limit})) else $error("lock");
   cover property (w1);
   cover property (sysclk_from_main_q);
   cover property (cpu_clk_tick);
endmodule // sclk_control_asserts
`default_nettype wire

// ==== tb/sclk_control_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module sclk_control_bench;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic rd_q = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] s = 8'h51;
   logic [31:0] rv = 32'h0420_6800;
   logic [7:0] exp_q[$];
   wire [7:0] reg_rdata_q;
   int fail_count = 0;
   int check_count = 0;
   always #5 core_clk = ~core_clk;
   sclk_control u_sclk_control (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata_q(reg_rdata_q),
      .main_osc_enable(), .low_speed_osc_enable(), .crystal_pins_to_osc(), .onchip_osc_ready(1'b1),
      .sysclk_from_main_q(), .sysclk_from_slow(), .cpu_clk_tick(), .cpu_div_limit());
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   // one bus cycle; on a read d is the expected data
   task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_write <= w;
      reg_read <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      if (!w) exp_q.push_back(d);
      @(posedge core_clk);
      reg_write <= 1'b0;
      reg_read <= 1'b0;
   endtask
   task automatic chk(input logic [7:0] got);
      check_count++;
      if (got !== exp_q.pop_front()) begin
         fail_count++;
         $display("MISMATCH %0t read data %h", $time, got);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge core_clk) begin
      rd_q <= reg_read;
      if (rd_q) chk(reg_rdata_q);
   end
   initial begin
      #150000;
      fail_count++;
      end_sim;
   end
   initial begin
      repeat (16) @(posedge core_clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         acc(1, i[3:0], 8'hFE);
         acc(0, i[3:0], rv[8*i +: 8]);
      end
      acc(1, 4'h0, 8'h01);
      repeat (3) begin
         s = lfsr(s);
         acc(1, 4'h1, s);
         acc(0, 4'h1, s & 8'hFE);
         acc(1, 4'h2, s);
         acc(0, 4'h2, s);
      end
      acc(1, 4'h9, 8'hFF);
      acc(0, 4'h9, 8'h00);
      acc(1, 4'h1, 8'h00);
      acc(1, 4'h2, 8'h08);
      acc(1, 4'h3, 8'h04);
      acc(0, 4'h3, 8'h04);
      acc(1, 4'h3, 8'h00);
      repeat (10010) @(posedge core_clk);
      acc(0, 4'h4, 8'h0F);
      acc(1, 4'h0, 8'h00);
      acc(1, 4'h1, 8'h80);
      acc(0, 4'h1, 8'h00);
      repeat (2) @(posedge core_clk);
      end_sim;
   end
endmodule // sclk_control_bench
bind sclk_control sclk_control_asserts u_sclk_control_asserts (.core_clk(core_clk), .reset_n(reset_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .main_osc_enable(main_osc_enable),
   .low_speed_osc_enable(low_speed_osc_enable), .crystal_pins_to_osc(crystal_pins_to_osc),
   .sysclk_from_main_q(sysclk_from_main_q), .sysclk_from_slow(sysclk_from_slow), .cpu_clk_tick(cpu_clk_tick),
   .cpu_div_limit(cpu_div_limit));
`default_nettype wire
